// ===== gpio_pwm_pkg.sv
// Shared constants for the GPIO and PWM output block
package gpio_pwm_pkg;
	localparam int          NUM_PWM    = 12;        // Modulated channels, pins 0 to 11
	localparam int          GROUP_SIZE = 6;         // Channels sharing one frequency
	localparam int          NUM_GROUPS = 2;         // Lower and upper group
	localparam int          PCT_W      = 7;         // Width of a percent value
	localparam int          STEP_W     = 16;        // Width of a step length
	localparam int          ADDR_W     = 8;         // Decoded address bits
	localparam logic [6:0]  PCT_FULL   = 7'h64;     // One hundred percent
	localparam logic [6:0]  PCT_LAST   = 7'h63;     // Last step of a period
	localparam logic [6:0]  PCT_ZERO   = 7'h00;     // Zero percent
	localparam logic [15:0] STEP_RESET = 16'h0019;  // Cycles per percent step after reset
	localparam logic [15:0] STEP_ONE   = 16'h0001;  // Shortest step length
	localparam logic [15:0] STEP_ZERO  = 16'h0000;  // Counter clear value
	// Register byte offsets
	localparam logic [7:0]  OFF_CTRL      = 8'h00;  // Run control
	localparam logic [7:0]  OFF_DIR       = 8'h04;  // Pin direction, 1 is output
	localparam logic [7:0]  OFF_OUT       = 8'h08;  // Output values
	localparam logic [7:0]  OFF_IN        = 8'h0C;  // Input truth, read only
	localparam logic [7:0]  OFF_FUNC      = 8'h10;  // 1 selects modulated function
	localparam logic [7:0]  OFF_STEP_LO   = 8'h14;  // Lower group step length
	localparam logic [7:0]  OFF_STEP_HI   = 8'h18;  // Upper group step length
	localparam logic [7:0]  OFF_DUTY_BASE = 8'h20;  // First duty word, one per channel
	localparam int          CTRL_RUN_BIT  = 0;      // Program running flag
	localparam int          HTRANS_ACT    = 1;      // NONSEQ or SEQ when set
	localparam logic [31:0] WORD_ZERO     = 32'h0000_0000; // Unmapped read value
endpackage : gpio_pwm_pkg

// ===== pwm_timebase.sv
// Group time base: percent step counter shared by six channels
`timescale 1ns/100ps
module pwm_timebase
	import gpio_pwm_pkg::*;
#(
	parameter int W = STEP_W                       // Step length width
) (
	input  wire logic         clk,                 // Core clock
	input  wire logic         rst,                 // Synchronous reset
	input  wire logic         run,                 // Program running
	input  wire logic [W-1:0] step_len,            // Requested cycles per step
	output logic [PCT_W-1:0]  pct,                 // Current percent step
	output logic              period_end           // Last cycle of a period
);
	logic [W-1:0] step_cur;                        // Step length in force
	logic [W-1:0] sub;                             // Cycle within a step
	logic [W-1:0] step_load;                       // Clamped request
	logic         sub_last;                        // Last cycle of a step

	// Zero length would stall the counter, so treat it as one
	assign step_load  = (step_len == W'(STEP_ZERO)) ? W'(STEP_ONE) : step_len;
	assign sub_last   = (sub >= step_cur - W'(STEP_ONE));
	assign period_end = run && sub_last && (pct == PCT_LAST);

	// Step and percent counters; new length taken while stopped and at a period boundary
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			sub      <= W'(STEP_ZERO);
			pct      <= PCT_ZERO;
			step_cur <= step_load;
		end else if (sub_last) begin
			sub <= W'(STEP_ZERO);
			if (pct == PCT_LAST) begin
				pct      <= PCT_ZERO;
				step_cur <= step_load;
			end else begin
				pct <= pct + 7'h01;
			end
		end else begin
			sub <= sub + W'(STEP_ONE);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_STEP_APPLY: assert property (period_end |=> step_cur == $past(step_load))
		else $error("new step length not applied at period end");
	AST_PCT_ADVANCE: assert property (run && sub_last && !period_end |=> run -> pct == $past(pct) + 7'h01)
		else $error("percent step did not advance");
	AST_STEP_HOLD: assert property (run && !sub_last |=> run -> pct == $past(pct))
		else $error("percent step moved inside a step");
endmodule : pwm_timebase

// ===== pwm_channel.sv
// One modulated channel: duty latch and compare
`timescale 1ns/100ps
module pwm_channel
	import gpio_pwm_pkg::*;
(
	input  wire logic             clk,             // Core clock
	input  wire logic             rst,             // Synchronous reset
	input  wire logic             run,             // Program running
	input  wire logic [PCT_W-1:0] duty,            // Requested on-time percent
	input  wire logic [PCT_W-1:0] pct,             // Group percent step
	input  wire logic             period_end,      // Group period boundary
	output logic                  pwm_out          // Modulated level
);
	logic [PCT_W-1:0] duty_l;                      // Duty in force this period

	// Duty follows freely before running, then only at period ends
	always_ff @(posedge clk) begin
		if (rst) begin
			duty_l <= PCT_ZERO;
		end else if (!run || period_end) begin
			duty_l <= duty;
		end
	end

	// Full scale stays high, zero stays low, no pulses before running
	assign pwm_out = run && (pct < duty_l);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_DUTY_FULL: assert property (run && duty_l == PCT_FULL |-> pwm_out)
		else $error("full duty did not hold output on");
	AST_DUTY_ZERO: assert property (duty_l == PCT_ZERO |-> !pwm_out)
		else $error("zero duty produced a pulse");
	AST_DUTY_LATCH: assert property (run && !period_end |=> duty_l == $past(duty_l))
		else $error("duty changed inside a period");
	AST_PWM_IDLE: assert property (!run |-> !pwm_out)
		else $error("pulse before program start");
endmodule : pwm_channel

// ===== gpio_pwm_top.sv
// GPIO pins with twelve shared PWM outputs behind an AHB-Lite slave
//
// Contract
// - Each pin independently input or output
// - Input reads true while pin is low
// - Inputs pass through without debounce
// - Output true drives the pin high
// - Pins pulled up until program runs
// - Claimed pin is never a GPIO
// - Twelve PWM channels on pins 0-11
// - Two groups of six, own frequency
// - Group frequency changeable while running
// - Duty in percent, 100 holds on
// - PWM pins idle pulled up before running
// - PWM pins: PWM or GPIO only; CLAIM still hands pins 0-11 to another peripheral while running
`timescale 1ns/100ps
module gpio_pwm_top
	import gpio_pwm_pkg::*;
#(
	parameter int NPINS = 16                       // GPIO pins, first twelve can modulate
) (
	input  wire logic             CORE_CLK,        // Core clock, 250 MHz
	input  wire logic             RST,             // Synchronous reset, active high
	input  wire logic             HSEL,            // Slave select
	input  wire logic [31:0]      HADDR,           // Byte address
	input  wire logic [1:0]       HTRANS,          // Transfer type
	input  wire logic             HWRITE,          // Write when high
	input  wire logic [2:0]       HSIZE,           // Word transfers only
	input  wire logic [31:0]      HWDATA,          // Write data
	input  wire logic             HREADY,          // Bus ready
	output logic [31:0]           HRDATA,          // Read data
	output logic                  HREADYOUT,       // Always ready
	output logic                  HRESP,           // Always OKAY
	input  wire logic [NPINS-1:0] GPIO_IN,         // Pin levels
	input  wire logic [NPINS-1:0] CLAIM,           // Pin taken by another peripheral
	output logic [NPINS-1:0]      GPIO_OUT,        // Pin drive level
	output logic [NPINS-1:0]      GPIO_OE,         // Pin drive enable
	output logic [NPINS-1:0]      GPIO_PULLUP      // Internal pull-up enable
);
	localparam int NFUNC = (NPINS < NUM_PWM) ? NPINS : NUM_PWM; // Pins able to modulate

	// Register state
	logic                   run;                   // Program running
	logic [NPINS-1:0]       dir;                   // 1 is output
	logic [NPINS-1:0]       out_val;               // Output truth
	logic [NPINS-1:0]       in_state;              // Input truth
	logic [NUM_PWM-1:0]     func;                  // Modulated function select
	logic [STEP_W-1:0]      step [NUM_GROUPS];     // Group step lengths
	logic [PCT_W-1:0]       duty [NUM_PWM];        // Channel duty settings
	// Bus state
	logic                   wr_pend;               // Write data phase pending
	logic [ADDR_W-1:0]      wr_addr;               // Latched write address
	logic                   take;                  // Address phase accepted
	logic [31:0]            next_rdata;            // Read mux
	// Modulator wiring
	logic [PCT_W-1:0]       grp_pct [NUM_GROUPS];  // Group percent steps
	logic [NUM_GROUPS-1:0]  grp_end;               // Group period ends
	logic [NUM_PWM-1:0]     pwm_out;               // Channel levels
	// Pin next values
	logic [NPINS-1:0]       next_oe;               // Drive enable
	logic [NPINS-1:0]       next_out;              // Drive level
	logic [NPINS-1:0]       next_pull;             // Pull-up
	logic [NPINS-1:0]       next_in;               // Input truth
	logic [NPINS-1:0]       sel;                   // Effective modulated select

	assign take = HSEL && HTRANS[HTRANS_ACT] && HREADY;

	// Write address phase capture; sizes other than word are not expected
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else begin
			wr_pend <= take && HWRITE;
			wr_addr <= HADDR[ADDR_W-1:0];
		end
	end

	// Zero wait states and always OKAY
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		next_rdata = WORD_ZERO;
		case (HADDR[ADDR_W-1:0])
			OFF_CTRL:    next_rdata = 32'(run);
			OFF_DIR:     next_rdata = 32'(dir);
			OFF_OUT:     next_rdata = 32'(out_val);
			OFF_IN:      next_rdata = 32'(in_state);
			OFF_FUNC:    next_rdata = 32'(func);
			OFF_STEP_LO: next_rdata = 32'(step[0]);
			OFF_STEP_HI: next_rdata = 32'(step[1]);
			default: begin
				for (int c = 0; c < NUM_PWM; c++) begin
					if (HADDR[ADDR_W-1:0] == 8'(OFF_DUTY_BASE + 4 * c)) begin
						next_rdata = 32'(duty[c]);
					end
				end
			end
		endcase
	end

	// Read data registered at the address phase, valid in the data phase
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			HRDATA <= WORD_ZERO;
		end else if (take && !HWRITE) begin
			HRDATA <= next_rdata;
		end
	end

	// Run flag; clearing it returns all pins to the pulled-up default
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			run <= 1'b0;
		end else if (wr_pend && wr_addr == OFF_CTRL) begin
			run <= HWDATA[CTRL_RUN_BIT];
		end
	end

	// Direction, output value and function select
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			dir     <= '0;
			out_val <= '0;
			func    <= '0;
		end else if (wr_pend) begin
			if (wr_addr == OFF_DIR) begin
				dir <= HWDATA[NPINS-1:0];
			end
			if (wr_addr == OFF_OUT) begin
				out_val <= HWDATA[NPINS-1:0];
			end
			if (wr_addr == OFF_FUNC) begin
				func <= HWDATA[NUM_PWM-1:0];
			end
		end
	end

	// Group step lengths, writable at any time
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			step[0] <= STEP_RESET;
			step[1] <= STEP_RESET;
		end else if (wr_pend) begin
			if (wr_addr == OFF_STEP_LO) begin
				step[0] <= HWDATA[STEP_W-1:0];
			end
			if (wr_addr == OFF_STEP_HI) begin
				step[1] <= HWDATA[STEP_W-1:0];
			end
		end
	end

	// Per channel duty; values above full scale clamp to full
	generate
		for (genvar c = 0; c < NUM_PWM; c++) begin : g_duty
			always_ff @(posedge CORE_CLK) begin
				if (RST) begin
					duty[c] <= PCT_ZERO;
				end else if (wr_pend && wr_addr == 8'(OFF_DUTY_BASE + 4 * c)) begin
					if (|HWDATA[31:PCT_W] || HWDATA[PCT_W-1:0] > PCT_FULL) begin
						duty[c] <= PCT_FULL;
					end else begin
						duty[c] <= HWDATA[PCT_W-1:0];
					end
				end
			end
		end
	endgenerate

	// One time base per group of six
	generate
		for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
			pwm_timebase #(
				.W          (STEP_W)
			) u_tb (
				.clk        (CORE_CLK),
				.rst        (RST),
				.run        (run),
				.step_len   (step[g]),
				.pct        (grp_pct[g]),
				.period_end (grp_end[g])
			);
		end
	endgenerate

	// Channel c follows group c / 6, so both groups run independently
	generate
		for (genvar c = 0; c < NUM_PWM; c++) begin : g_chan
			pwm_channel u_ch (
				.clk        (CORE_CLK),
				.rst        (RST),
				.run        (run),
				.duty       (duty[c]),
				.pct        (grp_pct[c / GROUP_SIZE]),
				.period_end (grp_end[c / GROUP_SIZE]),
				.pwm_out    (pwm_out[c])
			);
		end
	endgenerate

	// Pin function resolution, one slice per pin
	generate
		for (genvar i = 0; i < NPINS; i++) begin : g_pin
			if (i < NFUNC) begin : g_mod
				assign sel[i] = func[i];
			end else begin : g_plain
				assign sel[i] = 1'b0;
			end
			always_comb begin
				// A claimed pin is left to its owner while running: no drive, no pull
				next_oe[i]   = run && !CLAIM[i] && (sel[i] || dir[i]);
				next_out[i]  = next_oe[i] && (sel[i] ? pwm_out[i % NUM_PWM] : out_val[i]);
				next_pull[i] = !run || (!CLAIM[i] && !next_oe[i]);
				// Active low, raw level with no filtering
				next_in[i]   = run && !CLAIM[i] && !sel[i] && !dir[i] && !GPIO_IN[i];
			end
		end
	endgenerate

	// Pin outputs from flops; default is released with pull-up on
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			GPIO_OE     <= '0;
			GPIO_OUT    <= '0;
			GPIO_PULLUP <= '1;
			in_state    <= '0;
		end else begin
			GPIO_OE     <= next_oe;
			GPIO_OUT    <= next_out;
			GPIO_PULLUP <= next_pull;
			in_state    <= next_in;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	AST_PREBOOT_PULLUP: assert property (!run |=> GPIO_OE == '0 && GPIO_PULLUP == '1)
		else $error("pin not released with pull-up before start");
	AST_IN_ACTIVE_LOW: assert property (run && !dir[0] && !sel[0] && !CLAIM[0] |=> in_state[0] == !$past(GPIO_IN[0]))
		else $error("input truth not inverted pin level");
	AST_NO_DEBOUNCE: assert property (run && !dir[0] && !sel[0] && !CLAIM[0] && $changed(GPIO_IN[0]) |=> $changed(in_state[0]))
		else $error("input edge was filtered");
	AST_OUT_LEVEL: assert property (run && dir[1] && !sel[1] && !CLAIM[1] |=> GPIO_OE[1] && GPIO_OUT[1] == $past(out_val[1]))
		else $error("output pin level wrong");
	AST_CLAIMED: assert property (CLAIM[2] |=> !GPIO_OE[2] && !GPIO_PULLUP[2] || !$past(run))
		else $error("claimed pin still used as GPIO");
	AST_PWM_PIN: assert property (run && sel[3] && !CLAIM[3] |=> GPIO_OE[3] && GPIO_OUT[3] == $past(pwm_out[3]))
		else $error("modulated pin not driven by its channel");
	AST_PLAIN_PIN: assert property (run && !sel[4] && !dir[4] |=> !GPIO_OE[4])
		else $error("input pin driven");
	AST_GROUP_SHARE: assert property (duty[0] == duty[5] && !run ##1 run [*8] |-> pwm_out[0] == pwm_out[5])
		else $error("channels of one group out of step");

	COV_GROUPS_APART: cover property (run && grp_end[0] && !grp_end[1]);
	COV_FULL_DUTY: cover property (run && sel[0] && duty[0] == PCT_FULL ##1 GPIO_OUT[0]);
	COV_INPUT_TRUE: cover property (run && in_state[0]);
endmodule : gpio_pwm_top

// ===== pin_load_model.sv
// External load circuits on the pins: drivers, pull resistors and resolved level
`timescale 1ns/100ps
module pin_load_model #(
	parameter int N = 16                  // Pins modelled
) (
	input  wire logic [N-1:0] oe,         // Device drives the pin
	input  wire logic [N-1:0] out,        // Device drive level
	input  wire logic [N-1:0] pull_en,    // Device pull-up on
	input  wire logic [N-1:0] ext_en,     // Load circuit drives the pin
	input  wire logic [N-1:0] ext_lvl,    // Load circuit drive level
	output logic [N-1:0]      level       // Resolved pin level
);
	// Device driver first, then load driver, then pull-up
	// Board pull-down otherwise, so a released pin never glitches true
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (oe[i])
				level[i] = out[i];
			else if (ext_en[i])
				level[i] = ext_lvl[i];
			else
				level[i] = pull_en[i];
		end
	end
endmodule : pin_load_model

// ===== test_gpio_pwm_output_block.sv
// Self-checking bench for the GPIO pins and the twelve modulated outputs
`timescale 1ns/100ps
module test_gpio_pwm_output_block import gpio_pwm_pkg::*;;
	typedef struct packed {
		logic [31:0] exp;                 // Expected read word
		logic [31:0] msk;                 // Defined bits
	} note_t;
	logic        core_clk = 1'b0;         // Core clock
	logic        rst      = 1'b1;         // Reset, held at start
	logic        hsel     = 1'b0;         // Bus select
	logic [31:0] haddr    = 32'h0;        // Bus address
	logic [1:0]  htrans   = 2'h0;         // Bus transfer type
	logic        hwrite   = 1'b0;         // Bus direction
	logic [31:0] hwdata   = 32'h0;        // Bus write data
	logic [31:0] hrdata;                  // Bus read data
	logic        hreadyout;               // Slave ready, fed back as hready
	logic        hresp;                   // Slave response
	logic [15:0] gpio_in;                 // Resolved pin levels
	logic [15:0] claim    = 16'h0;        // Pins owned elsewhere
	logic [15:0] gpio_out;                // Device drive level
	logic [15:0] gpio_oe;                 // Device drive enable
	logic [15:0] gpio_pullup;             // Device pull-ups
	logic [15:0] ext_en   = 16'h0;        // Load drives pin
	logic [15:0] ext_lvl  = 16'h0;        // Load level
	logic [15:0] dir;                     // Last direction written
	logic [15:0] outv;                    // Last output word written
	logic [6:0]  eff [12];                // Effective duty per channel
	logic        rd_dphase = 1'b0;        // Read data phase in progress
	note_t       notes[$];                // Expected read results
	int          error_cnt   = 0;         // Mismatches
	int          comparisons = 0;         // Compares made

	// Free-running 250 MHz clock
	always #2 core_clk = ~core_clk;

	gpio_pwm_top #(.NPINS(16)) u_gpio_pwm_top (
		.CORE_CLK(core_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .GPIO_IN(gpio_in), .CLAIM(claim),
		.GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .GPIO_PULLUP(gpio_pullup));

	pin_load_model #(.N(16)) u_pin_load_model (
		.oe(gpio_oe), .out(gpio_out), .pull_en(gpio_pullup), .ext_en(ext_en),
		.ext_lvl(ext_lvl), .level(gpio_in));

	// Single compare point
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Counts line, verdict, end of run
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// One bus transfer; address phase held until ready, then data phase
	task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
	endtask : ahb_xfer

	// Read: expectation noted first, compared by the monitor
	task automatic ahb_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		notes.push_back('{exp: exp, msk: msk});
		ahb_xfer(1'b0, a, 32'h0);
	endtask : ahb_rd

	// Read monitor: data sampled at the edge closing the data phase
	always @(posedge core_clk) begin : rd_mon
		note_t n;
		if (rd_dphase && hreadyout === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			check("HRDATA", hrdata & n.msk, n.exp & n.msk);
			check("HRESP", {31'h0, hresp}, 32'h0);
		end
		rd_dphase <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	// Pin state compare; msk limits which driven levels count
	task automatic pins_chk(input logic [15:0] oe, input logic [15:0] out, input logic [15:0] pu,
			input logic [15:0] msk);
		check("GPIO_OE", {16'h0, gpio_oe}, {16'h0, oe});
		check("GPIO_OUT", {16'h0, gpio_out & gpio_oe & msk}, {16'h0, out & msk});
		check("GPIO_PULLUP", {16'h0, gpio_pullup}, {16'h0, pu});
	endtask : pins_chk

	// High and rising counts per channel over whole periods
	task automatic pwm_measure(input int n, input int lo_rises, input int hi_rises);
		int          highs[12];
		int          rises[12];
		int          er;
		logic [11:0] prev;
		logic [11:0] lvl;
		highs = '{default: 0};
		rises = '{default: 0};
		prev  = gpio_out[11:0] & gpio_oe[11:0];
		repeat (n) begin
			@(posedge core_clk);
			lvl = gpio_out[11:0] & gpio_oe[11:0];
			for (int c = 0; c < 12; c++) begin
				highs[c] += int'(lvl[c]);
				rises[c] += int'(lvl[c] && !prev[c]);
			end
			prev = lvl;
		end
		for (int c = 0; c < NUM_PWM; c++) begin
			// Full and zero duty never toggle
			er = (eff[c] == PCT_ZERO || eff[c] == PCT_FULL) ? 0 : (c < GROUP_SIZE) ? lo_rises : hi_rises;
			check("pwm high count", 32'(highs[c]), 32'(int'(eff[c]) * n / 100));
			check("pwm rise count", 32'(rises[c]), 32'(er));
		end
	endtask : pwm_measure

	// Main sequence
	initial begin
		void'($urandom(32'hC7CD));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		pins_chk(16'h0, 16'h0, 16'hFFFF, 16'hFFFF);
		ahb_rd(OFF_STEP_LO, {16'h0, STEP_RESET}, 32'hFFFF_FFFF);
		ahb_rd(8'h1C, WORD_ZERO, 32'hFFFF_FFFF);
		// Outputs requested before start must stay released
		ahb_xfer(1'b1, OFF_DIR, 32'hFFFF);
		ahb_xfer(1'b1, OFF_OUT, 32'hFFFF);
		repeat (3) @(posedge core_clk);
		pins_chk(16'h0, 16'h0, 16'hFFFF, 16'hFFFF);
		// Step lengths set before start: a running group only takes a new one
		// at its period end, and the reset length would make that period long
		ahb_xfer(1'b1, OFF_STEP_LO, 32'h1);
		ahb_xfer(1'b1, OFF_STEP_HI, 32'h2);
		ahb_xfer(1'b1, OFF_CTRL, 32'h1);
		// Random mixes of inputs and outputs, PWM pins as plain GPIO
		repeat (4) begin
			dir  = 16'($urandom);
			outv = 16'($urandom);
			ahb_xfer(1'b1, OFF_DIR, {16'h0, dir});
			ahb_xfer(1'b1, OFF_OUT, {16'h0, outv});
			ext_en  <= ~dir;
			ext_lvl <= 16'($urandom);
			repeat (3) @(posedge core_clk);
			pins_chk(dir, outv & dir, ~dir, 16'hFFFF);
			ahb_rd(OFF_IN, {16'h0, ~ext_lvl}, {16'h0, ~dir});
		end
		// Pins claimed by another function drop out of GPIO
		claim <= 16'($urandom);
		repeat (3) @(posedge core_clk);
		pins_chk(dir & ~claim, outv & dir & ~claim, ~dir & ~claim, 16'hFFFF);
		ahb_rd(OFF_IN, {16'h0, ~ext_lvl & ~claim}, {16'h0, ~dir});
		claim  <= 16'h0;
		ext_en <= 16'h0;
		// Modulated channels: lower group step 1, upper step 2
		ahb_xfer(1'b1, OFF_DIR, 32'h0);
		for (int c = 0; c < NUM_PWM; c++) begin
			eff[c] = (c == 2) ? PCT_ZERO : (c == 3) ? PCT_FULL : 7'($urandom_range(99, 1));
			ahb_xfer(1'b1, OFF_DUTY_BASE + 8'(4 * c), (c == 3) ? 32'h96 : {25'h0, eff[c]});
		end
		ahb_xfer(1'b1, OFF_FUNC, 32'hFFF);
		repeat (400) @(posedge core_clk);
		pins_chk(16'h0FFF, 16'h0, 16'hF000, 16'hF000);
		pwm_measure(200, 2, 1);
		// Frequency change while running
		ahb_xfer(1'b1, OFF_STEP_LO, 32'h4);
		repeat (800) @(posedge core_clk);
		pwm_measure(400, 1, 2);
		ahb_xfer(1'b1, OFF_CTRL, 32'h0);
		repeat (3) @(posedge core_clk);
		pins_chk(16'h0, 16'h0, 16'hFFFF, 16'hFFFF);
		print_verdict();
	end

	// Watchdog, well beyond the under two thousand cycles needed
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		$display("[ERR] run expected finish seen timeout");
		print_verdict();
	end
endmodule : test_gpio_pwm_output_block
